// ### hw/rlf_config_regs.v
// Purpose: AHB-Lite configuration bank, resets, sync timer, hyperframes.
// Assumes: One clock; bus and lane-facing logic share ref_clk_i.
// Notes:   Lane domains are collapsed onto the one clock.
// Summary of operation
// R1 - Initiator base 0x60070000, target base 0x60060000
// R2 - Software programs control word last
// R3 - Offset 0x04 holds transmit sequence limit
// R4 - Offset 0x08 holds receive sequence limit
// R5 - K character copies at 0x0C, 0x10
// R6 - First D character copies at 0x14, 0x18
// R7 - Remaining D character copies at 0x1C, 0x20
// R8 - Transmit Ethernet pointer at 0x2C
// R9 - Receive Ethernet pointer at 0x30
// R10 - Protocol version at 0x24, value one
// R11 - Offset 0x100 sets L1 sync timeout
// R12 - Offset 0x104 sets hyperframe length count
// R13 - Control bits enable mapper, demapper, sync, core
// R14 - Framing logic on lane clock, apart from bus
// R15 - AHB port in the bus clock domain
// R16 - Bus reset needs lock, external reset, init done
// R17 - Lane resets need external reset, init done
// R18 - Lane 0 initiator, lane 1 target
// R19 - Reads return last write; safe transfer to lanes
`include "rlf_regs.vh"
`default_nettype none

module rlf_config_regs #(
  parameter IS_TARGET = 0
) (
  input wire ref_clk_i,
  input wire sys_rst_i,
  input wire ce_i,
  input wire external_reset_n_i,
  input wire pll_lock_i,
  input wire init_done_i,
  input wire sync_ok_i,
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hready_o,
  output reg hresp_o,
  output reg bus_rst_n_o,
  output reg lane_tx_rst_n_o,
  output reg lane_rx_rst_n_o,
  output reg map_en_o,
  output reg demap_en_o,
  output reg l1_sync_en_o,
  output reg core_en_o,
  output reg [7:0] tx_sequence_limit_o,
  output reg [7:0] rx_sequence_limit_o,
  output reg [7:0] tx_sync_k_o,
  output reg [7:0] rx_sync_k_o,
  output reg [7:0] tx_sync_d_first_o,
  output reg [7:0] rx_sync_d_first_o,
  output reg [7:0] tx_sync_d_rest_o,
  output reg [7:0] rx_sync_d_rest_o,
  output reg [7:0] tx_protocol_version_o,
  output reg [7:0] tx_eth_pointer_o,
  output reg [7:0] rx_eth_pointer_o,
  output reg sync_timeout_o,
  output reg hf_start_o
);

  // Base address follows the lane role
  localparam [31:0] BASE = IS_TARGET ? `RLF_BASE_TGT : `RLF_BASE_INIT; // R1
  localparam LANE_ID = IS_TARGET ? 1 : 0; // R18
  localparam [3:0] S_CTRL = 4'h0;
  localparam [3:0] S_TX_SEQ = 4'h1;
  localparam [3:0] S_RX_SEQ = 4'h2;
  localparam [3:0] S_TX_K = 4'h3;
  localparam [3:0] S_RX_K = 4'h4;
  localparam [3:0] S_TX_D1 = 4'h5;
  localparam [3:0] S_RX_D1 = 4'h6;
  localparam [3:0] S_TX_DY = 4'h7;
  localparam [3:0] S_RX_DY = 4'h8;
  localparam [3:0] S_TX_VER = 4'h9;
  localparam [3:0] S_TX_ETH = 4'hA;
  localparam [3:0] S_RX_ETH = 4'hB;
  localparam [3:0] S_TIMEOUT = 4'hC;
  localparam [3:0] S_HF_LEN = 4'hD;
  // Bus response states
  localparam [1:0] B_IDLE = 2'b00;
  localparam [1:0] B_DATA = 2'b01;
  localparam [1:0] B_ERR1 = 2'b10;

  // Offset to storage slot
  function [3:0] slot_of;
    input [11:0] ofs;
    begin
      case (ofs)
        `RLF_OFS_CTRL: slot_of = S_CTRL; // R13
        `RLF_OFS_TX_SEQ: slot_of = S_TX_SEQ; // R3
        `RLF_OFS_RX_SEQ: slot_of = S_RX_SEQ; // R4
        `RLF_OFS_TX_K: slot_of = S_TX_K; // R5
        `RLF_OFS_RX_K: slot_of = S_RX_K; // R5
        `RLF_OFS_TX_D1: slot_of = S_TX_D1; // R6
        `RLF_OFS_RX_D1: slot_of = S_RX_D1; // R6
        `RLF_OFS_TX_DY: slot_of = S_TX_DY; // R7
        `RLF_OFS_RX_DY: slot_of = S_RX_DY; // R7
        `RLF_OFS_TX_VER: slot_of = S_TX_VER; // R10
        `RLF_OFS_TX_ETH: slot_of = S_TX_ETH; // R8
        `RLF_OFS_RX_ETH: slot_of = S_RX_ETH; // R9
        `RLF_OFS_TIMEOUT: slot_of = S_TIMEOUT; // R11
        `RLF_OFS_HF_LEN: slot_of = S_HF_LEN; // R12
        `RLF_OFS_STATUS: slot_of = `RLF_SLOT_STATUS;
        default: slot_of = `RLF_SLOT_NONE;
      endcase
    end
  endfunction

  // Reset value of each slot
  function [31:0] rst_val;
    input [3:0] s;
    begin
      case (s)
        S_TX_SEQ, S_RX_SEQ: rst_val = `RLF_RST_SEQ;
        S_TX_K, S_RX_K: rst_val = `RLF_RST_K;
        S_TX_D1, S_RX_D1, S_TX_DY, S_RX_DY: rst_val = `RLF_RST_D;
        S_TX_VER: rst_val = `RLF_RST_VER;
        S_TX_ETH, S_RX_ETH: rst_val = `RLF_RST_ETH;
        S_TIMEOUT: rst_val = `RLF_RST_TIMEOUT;
        S_HF_LEN: rst_val = `RLF_RST_HF_LEN;
        default: rst_val = `RLF_RST_CTRL;
      endcase
    end
  endfunction

  // Byte lane mask from transfer size and low address bits
  function [3:0] lane_mask;
    input [2:0] size;
    input [1:0] a;
    begin
      case (size)
        3'b000: lane_mask = 4'h1 << a;
        3'b001: lane_mask = a[1] ? 4'hC : 4'h3;
        default: lane_mask = 4'hF;
      endcase
    end
  endfunction

  // Merge written bytes over the old word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] m;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (m[b]) begin
          merge[b*8 +: 8] = wd[b*8 +: 8];
        end
      end
    end
  endfunction

  reg [31:0] cfg_q [0:`RLF_NUM_SLOTS-1];
  reg [1:0] bus_st_q;
  reg [3:0] wr_slot_q;
  reg [3:0] wr_mask_q;
  reg wr_pend_q;
  reg lane_rel_q;
  reg [31:0] tmo_cnt_q;
  reg [31:0] hf_cnt_q;
  wire [3:0] a_slot;
  wire a_hit;
  wire a_go;
  wire a_bad;
  wire [3:0] a_mask;
  wire [31:0] a_word;
  wire [31:0] status_w;
  wire [31:0] ctrl_w;
  integer i;

  // Address phase decode; the 4 KB window sits at the core base
  assign a_go = hsel_i & hready_i & htrans_i[1]; // R15
  assign a_hit = haddr_i[31:`RLF_WIN_BITS] == BASE[31:`RLF_WIN_BITS]; // R1
  assign a_slot = slot_of(haddr_i[11:0] & 12'hFFC);
  assign a_bad = ~a_hit | (a_slot == `RLF_SLOT_NONE);
  assign a_mask = lane_mask(hsize_i, haddr_i[1:0]);
  assign ctrl_w = cfg_q[S_CTRL];

  // Status shows reset release, sync timeout and lane role
  assign status_w = {28'h0000000, LANE_ID[0], sync_timeout_o, lane_rel_q,
                     bus_rst_n_o}; // R18

  // Read word; a write still in its data phase is forwarded, so a
  // back-to-back read never returns the stale value
  assign a_word = (a_slot == `RLF_SLOT_STATUS) ? status_w :
                  (wr_pend_q && wr_slot_q == a_slot) ?
                  merge(cfg_q[a_slot], hwdata_i, wr_mask_q) :
                  cfg_q[a_slot]; // R19

  // Reset release from the board-level conditions
  always @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      bus_rst_n_o <= 1'b0;
      lane_tx_rst_n_o <= 1'b0;
      lane_rx_rst_n_o <= 1'b0;
      lane_rel_q <= 1'b0;
    end else if (ce_i) begin
      bus_rst_n_o <= pll_lock_i & external_reset_n_i & init_done_i; // R16
      lane_rel_q <= external_reset_n_i & init_done_i; // R17
      lane_tx_rst_n_o <= external_reset_n_i & init_done_i; // R17
      lane_rx_rst_n_o <= external_reset_n_i & init_done_i; // R17
    end
  end

  // AHB-Lite slave: zero wait for mapped words, two-cycle ERROR otherwise
  always @(posedge ref_clk_i) begin
    if (sys_rst_i || !bus_rst_n_o) begin
      bus_st_q <= B_IDLE;
      hready_o <= 1'b1;
      hresp_o <= 1'b0;
      hrdata_o <= 32'h00000000;
      wr_pend_q <= 1'b0;
      wr_slot_q <= 4'h0;
      wr_mask_q <= 4'h0;
    end else if (ce_i) begin
      case (bus_st_q)
        B_ERR1: begin
          bus_st_q <= B_IDLE;
          hready_o <= 1'b1;
          hresp_o <= 1'b1;
        end
        default: begin
          hresp_o <= 1'b0;
          hready_o <= 1'b1;
          wr_pend_q <= 1'b0;
          bus_st_q <= B_IDLE;
          if (a_go) begin
            if (a_bad) begin
              bus_st_q <= B_ERR1;
              hready_o <= 1'b0;
              hresp_o <= 1'b1;
              hrdata_o <= 32'h00000000;
            end else begin
              bus_st_q <= B_DATA;
              wr_pend_q <= hwrite_i & (a_slot != `RLF_SLOT_STATUS);
              wr_slot_q <= a_slot;
              wr_mask_q <= a_mask;
              hrdata_o <= hwrite_i ? 32'h00000000 : a_word; // R19
            end
          end
        end
      endcase
    end
  end

  // Register storage, written in the data phase
  always @(posedge ref_clk_i) begin
    if (sys_rst_i || !bus_rst_n_o) begin
      for (i = 0; i < `RLF_NUM_SLOTS; i = i + 1) begin
        cfg_q[i] <= rst_val(i[3:0]);
      end
    end else if (ce_i && wr_pend_q) begin
      cfg_q[wr_slot_q] <= merge(cfg_q[wr_slot_q], hwdata_i, wr_mask_q); // R19
    end
  end

  // Lane-facing copies; held in reset until the lane is released, and
  // taken from settled storage so a field never changes mid-word
  always @(posedge ref_clk_i) begin
    if (sys_rst_i || !lane_rel_q) begin
      map_en_o <= 1'b0;
      demap_en_o <= 1'b0;
      l1_sync_en_o <= 1'b0;
      core_en_o <= 1'b0;
      tx_sequence_limit_o <= 8'h00;
      rx_sequence_limit_o <= 8'h00;
      tx_sync_k_o <= 8'h00;
      rx_sync_k_o <= 8'h00;
      tx_sync_d_first_o <= 8'h00;
      rx_sync_d_first_o <= 8'h00;
      tx_sync_d_rest_o <= 8'h00;
      rx_sync_d_rest_o <= 8'h00;
      tx_protocol_version_o <= 8'h00;
      tx_eth_pointer_o <= 8'h00;
      rx_eth_pointer_o <= 8'h00;
    end else if (ce_i) begin
      map_en_o <= ctrl_w[`RLF_CTRL_MAP]; // R13
      demap_en_o <= ctrl_w[`RLF_CTRL_DEMAP]; // R13
      l1_sync_en_o <= ctrl_w[`RLF_CTRL_L1]; // R13
      core_en_o <= ctrl_w[`RLF_CTRL_CORE]; // R13
      tx_sequence_limit_o <= cfg_q[S_TX_SEQ][7:0]; // R3
      rx_sequence_limit_o <= cfg_q[S_RX_SEQ][7:0]; // R4
      tx_sync_k_o <= cfg_q[S_TX_K][7:0]; // R5
      rx_sync_k_o <= cfg_q[S_RX_K][7:0]; // R5
      tx_sync_d_first_o <= cfg_q[S_TX_D1][7:0]; // R6
      rx_sync_d_first_o <= cfg_q[S_RX_D1][7:0]; // R6
      tx_sync_d_rest_o <= cfg_q[S_TX_DY][7:0]; // R7
      rx_sync_d_rest_o <= cfg_q[S_RX_DY][7:0]; // R7
      tx_protocol_version_o <= cfg_q[S_TX_VER][7:0]; // R10
      tx_eth_pointer_o <= cfg_q[S_TX_ETH][7:0]; // R8
      rx_eth_pointer_o <= cfg_q[S_RX_ETH][7:0]; // R9
    end
  end

  // L1 sync timer: runs while sync is enabled and not yet achieved;
  // the flag holds until sync is seen or the machine is disabled
  always @(posedge ref_clk_i) begin
    if (sys_rst_i || !lane_rel_q) begin
      tmo_cnt_q <= 32'h00000000;
      sync_timeout_o <= 1'b0;
    end else if (ce_i) begin
      if (!l1_sync_en_o || sync_ok_i) begin
        tmo_cnt_q <= 32'h00000000;
        sync_timeout_o <= 1'b0;
      end else if (tmo_cnt_q >= cfg_q[S_TIMEOUT]) begin
        sync_timeout_o <= 1'b1; // R11
      end else begin
        tmo_cnt_q <= tmo_cnt_q + 32'h00000001; // R11
      end
    end
  end

  // Hyperframe counter: wraps after the programmed count, pulsing at start
  always @(posedge ref_clk_i) begin
    if (sys_rst_i || !lane_rel_q) begin
      hf_cnt_q <= 32'h00000000;
      hf_start_o <= 1'b0;
    end else if (ce_i) begin
      if (!core_en_o) begin
        hf_cnt_q <= 32'h00000000;
        hf_start_o <= 1'b0;
      end else if (hf_cnt_q >= cfg_q[S_HF_LEN]) begin
        hf_cnt_q <= 32'h00000000; // R12
        hf_start_o <= 1'b1;
      end else begin
        hf_cnt_q <= hf_cnt_q + 32'h00000001; // R12
        hf_start_o <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// ### hw/rlf_regs.vh
// Purpose: Register map, reset values and field positions of the framer
//          configuration bank.
// Assumes: Byte addresses relative to the core base, one 32-bit word each.
// Notes:   Definitions only.
`ifndef RLF_REGS_VH
`define RLF_REGS_VH

// Core base addresses
`define RLF_BASE_INIT 32'h60070000
`define RLF_BASE_TGT 32'h60060000
`define RLF_WIN_BITS 12

// Register byte offsets
`define RLF_OFS_CTRL 12'h000
`define RLF_OFS_TX_SEQ 12'h004
`define RLF_OFS_RX_SEQ 12'h008
`define RLF_OFS_TX_K 12'h00C
`define RLF_OFS_RX_K 12'h010
`define RLF_OFS_TX_D1 12'h014
`define RLF_OFS_RX_D1 12'h018
`define RLF_OFS_TX_DY 12'h01C
`define RLF_OFS_RX_DY 12'h020
`define RLF_OFS_TX_VER 12'h024
`define RLF_OFS_TX_ETH 12'h02C
`define RLF_OFS_RX_ETH 12'h030
`define RLF_OFS_TIMEOUT 12'h100
`define RLF_OFS_HF_LEN 12'h104
`define RLF_OFS_STATUS 12'h108

// Reset values, equal to the usual programming values
`define RLF_RST_CTRL 32'h00000000
`define RLF_RST_SEQ 32'h0000001F
`define RLF_RST_K 32'h000000BC
`define RLF_RST_D 32'h00000050
`define RLF_RST_VER 32'h00000001
`define RLF_RST_ETH 32'h00000014
`define RLF_RST_TIMEOUT 32'h000F4240
`define RLF_RST_HF_LEN 32'h00001FFF

// Control word fields
`define RLF_CTRL_MAP 0
`define RLF_CTRL_DEMAP 1
`define RLF_CTRL_L1 2
`define RLF_CTRL_CORE 3

// Status word fields
`define RLF_ST_BUS_REL 0
`define RLF_ST_LANE_REL 1
`define RLF_ST_TIMEOUT 2
`define RLF_ST_LANE_ID 3

// Register slots; 4'hF marks an unmapped offset
`define RLF_SLOT_STATUS 4'hE
`define RLF_SLOT_NONE 4'hF
`define RLF_NUM_SLOTS 14

`endif

// ### sim/rlf_ahb_host.sv
// Purpose: AHB-Lite initiator standing in for the embedded processor
// Assumes: Bench drives transfer size; slave hready is fed back
// Notes: Idle write data shows the inverse of its last value
`default_nettype none
module rlf_ahb_host (
  input wire logic clk_i,
  input wire logic hready_i,
  input wire logic hresp_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [31:0] hwdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle from time zero
  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hwdata_o = 32'h0;
  end
  // One transfer; data phase held until the slave reports ready
  task automatic xfer(input logic wr, input logic [31:0] a, d,
                      output logic [31:0] rd, output logic rsp);
    int n;
    @(posedge clk_i);
    hsel_o <= 1'b1;
    haddr_o <= a;
    htrans_o <= 2'h2;
    hwrite_o <= wr;
    @(posedge clk_i);
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    haddr_o <= ~a;
    hwdata_o <= wr ? d : ~hwdata_o;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hready_i !== 1'b1 && n < 9);
    rd = hrdata_i;
    rsp = hresp_i;
  endtask
  // Write then read of one address, back to back: the read address phase
  // overlaps the write data phase, so the slave must forward the new word.
  // Only for mapped words, which answer with no wait state.
  task automatic wr_rd(input logic [31:0] a, d,
                       output logic [31:0] rd, output logic rsp);
    @(posedge clk_i);
    hsel_o <= 1'b1;
    haddr_o <= a;
    htrans_o <= 2'h2;
    hwrite_o <= 1'b1;
    @(posedge clk_i);
    hwrite_o <= 1'b0;
    hwdata_o <= d;
    @(posedge clk_i);
    hsel_o <= 1'b0;
    htrans_o <= 2'h0;
    haddr_o <= ~a;
    hwdata_o <= ~d;
    @(posedge clk_i);
    rd = hrdata_i;
    rsp = hresp_i || hready_i !== 1'b1;
  endtask
endmodule
`default_nettype wire

// ### sim/rlf_config_regs_assertions.sv
// Purpose: Port assertions for the framer configuration bank
// Assumes: One clock, synchronous active-high reset, ce_i low only briefly
// Notes: Lane copies lag the register by one edge
`default_nettype none
module rlf_chk #(parameter IS_TARGET = 0) (
  input wire logic ref_clk_i, sys_rst_i, ce_i, sync_ok_i,
  input wire logic external_reset_n_i, pll_lock_i, init_done_i,
  input wire logic hsel_i, hwrite_i, hready_i,
  input wire logic [1:0] htrans_i,
  input wire logic [31:0] haddr_i, hwdata_i,
  input wire logic hready_o, hresp_o, bus_rst_n_o, lane_tx_rst_n_o,
  input wire logic lane_rx_rst_n_o, map_en_o, demap_en_o, l1_sync_en_o,
  input wire logic core_en_o, sync_timeout_o, hf_start_o
);
  localparam logic [19:0] BASE = IS_TARGET ? 20'h60060 : 20'h60070;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Transfer taken and its decode
  wire logic tk = ce_i && hsel_i && hready_i && htrans_i[1] && bus_rst_n_o;
  wire logic hit = haddr_i[31:12] == BASE;
  wire logic ok = external_reset_n_i && init_done_i;
  // Reset is sampled in the antecedent: disable iff sees the released
  // level already at the edge on which reset drops
  AST_BUS_ON: assert property (!sys_rst_i && ce_i && ok && pll_lock_i
    |=> bus_rst_n_o) else $error("bus reset not released");
  AST_BUS_OFF: assert property (ce_i && !pll_lock_i |=> !bus_rst_n_o)
    else $error("bus reset released without lock");
  AST_LANE_ON: assert property (!sys_rst_i && ce_i && ok
    |=> lane_tx_rst_n_o) else $error("lane reset not released");
  AST_LANE_OFF: assert property (ce_i && !init_done_i |=> !lane_rx_rst_n_o)
    else $error("lane reset released early");
  AST_BAD_BASE: assert property (tk && !hit |=> !hready_o && hresp_o ##1 hready_o && hresp_o)
    else $error("unmapped access not refused");
  AST_GOOD_RD: assert property (tk && hit && haddr_i[11:0] == 12'h004 |=> hready_o && !hresp_o)
    else $error("mapped read refused");
  AST_CTRL: assert property (tk && hit && hwrite_i && haddr_i[11:0] == 12'h000 ##1 hwdata_i[3:0] == 4'hF |-> ##[1:2] map_en_o && demap_en_o && l1_sync_en_o && core_en_o)
    else $error("control enables not set");
  AST_HF_CORE: assert property (hf_start_o |-> $past(core_en_o))
    else $error("hyperframe pulse while core off");
  AST_TMO_OK: assert property (sync_ok_i [*3] |-> !sync_timeout_o)
    else $error("timeout stands while synced");
  cover property (tk && !hit);
  cover property (hf_start_o);
  cover property (sync_timeout_o);
endmodule
bind rlf_config_regs rlf_chk #(.IS_TARGET(IS_TARGET)) u_chk (.ref_clk_i,
  .sys_rst_i, .ce_i, .sync_ok_i, .external_reset_n_i, .pll_lock_i,
  .init_done_i, .hsel_i, .hwrite_i, .hready_i,
  .htrans_i, .haddr_i, .hwdata_i, .hready_o, .hresp_o, .bus_rst_n_o,
  .lane_tx_rst_n_o, .lane_rx_rst_n_o, .map_en_o, .demap_en_o,
  .l1_sync_en_o, .core_en_o, .sync_timeout_o, .hf_start_o);
`default_nettype wire

// ### sim/test_radio_link_framer_config_regs.sv
// Purpose: Self-checking bench for the framer configuration bank
// Assumes: Initiator instance, ce_i high except one pause in t_hyper, word-sized transfers except one byte write
// Notes: Short timeout and hyperframe lengths keep the run brief
`default_nettype none
module test_radio_link_framer_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] BASE = 32'h60070000;
  int err_total, check_count;
  logic [31:0] rd;
  logic rsp;
  logic ref_clk_i, sys_rst_i, ce_i, external_reset_n_i, pll_lock_i;
  logic init_done_i, sync_ok_i, hsel_i, hwrite_i, hready_o, hresp_o;
  logic bus_rst_n_o, lane_tx_rst_n_o, lane_rx_rst_n_o, map_en_o;
  logic demap_en_o, l1_sync_en_o, core_en_o, sync_timeout_o, hf_start_o;
  logic [1:0] htrans_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o;
  logic [7:0] tx_sequence_limit_o, rx_sequence_limit_o, tx_sync_k_o;
  logic [7:0] rx_sync_k_o, tx_sync_d_first_o, rx_sync_d_first_o;
  logic [7:0] tx_sync_d_rest_o, rx_sync_d_rest_o, tx_protocol_version_o;
  logic [7:0] tx_eth_pointer_o, rx_eth_pointer_o;
  logic [2:0] hsize_i = 3'h2;
  wire logic hready_i = hready_o;
  // Lane copies in programming order, first entry in the low byte
  wire logic [87:0] cp = {rx_eth_pointer_o, tx_protocol_version_o,
    tx_eth_pointer_o, rx_sync_d_rest_o, tx_sync_d_rest_o, rx_sync_d_first_o,
    tx_sync_d_first_o, rx_sync_k_o, tx_sync_k_o, rx_sequence_limit_o,
    tx_sequence_limit_o};
  logic [11:0] ofs [14] = '{12'h004, 12'h008, 12'h00C, 12'h010, 12'h014,
    12'h018, 12'h01C, 12'h020, 12'h02C, 12'h024, 12'h030, 12'h100, 12'h104,
    12'h000};
  logic [31:0] rv [14] = '{32'h1F, 32'h1F, 32'hBC, 32'hBC, 32'h50, 32'h50,
    32'h50, 32'h50, 32'h14, 32'h01, 32'h14, 32'hF4240, 32'h1FFF, 32'h0};
  rlf_config_regs dut (.ref_clk_i, .sys_rst_i, .ce_i, .external_reset_n_i,
    .pll_lock_i, .init_done_i, .sync_ok_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o, .hready_o,
    .hresp_o, .bus_rst_n_o, .lane_tx_rst_n_o, .lane_rx_rst_n_o, .map_en_o,
    .demap_en_o, .l1_sync_en_o, .core_en_o, .tx_sequence_limit_o,
    .rx_sequence_limit_o, .tx_sync_k_o, .rx_sync_k_o, .tx_sync_d_first_o,
    .rx_sync_d_first_o, .tx_sync_d_rest_o, .rx_sync_d_rest_o,
    .tx_protocol_version_o, .tx_eth_pointer_o, .rx_eth_pointer_o,
    .sync_timeout_o, .hf_start_o);
  rlf_ahb_host host (.clk_i(ref_clk_i), .hready_i(hready_o),
    .hresp_i(hresp_o), .hrdata_i(hrdata_o), .hsel_o(hsel_i),
    .haddr_o(haddr_i), .htrans_o(htrans_i), .hwrite_o(hwrite_i),
    .hwdata_o(hwdata_i));
  task automatic cmp(input logic [87:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick;
    @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr(input logic [11:0] o, input logic [31:0] d);
    host.xfer(1'b1, BASE | o, d, rd, rsp);
  endtask
  // Read must answer OKAY with the expected word
  task automatic rdc(input logic [11:0] o, input logic [31:0] e);
    host.xfer(1'b0, BASE | o, 32'h0, rd, rsp);
    cmp({rsp, rd}, {1'b0, e});
  endtask
  task automatic t_reset;
    logic [87:0] ex;
    for (int i = 0; i < 14; i++) begin
      rdc(ofs[i], rv[i]);
      if (i < 11) ex[8*i +: 8] = rv[i][7:0];
    end
    cmp(cp, ex);
    $display("reset value test done");
  endtask
  task automatic t_program;
    logic [31:0] v;
    logic [87:0] ex;
    for (int i = 0; i < 14; i++) begin
      v = (i == 13) ? 32'hF : 32'hA5C30040 + i;
      wr(ofs[i], v);
      rdc(ofs[i], v);
      if (i < 11) ex[8*i +: 8] = v[7:0];
    end
    repeat (3) tick;
    cmp(cp, ex);
    cmp({map_en_o, demap_en_o, l1_sync_en_o, core_en_o}, 4'hF);
    $display("program test done");
  endtask
  task automatic t_error;
    host.xfer(1'b0, BASE | 32'h028, 32'h0, rd, rsp);
    cmp(rsp, 1'b1);
    host.xfer(1'b1, 32'h60060004, 32'h77, rd, rsp);
    cmp(rsp, 1'b1);
    rdc(12'h004, 32'hA5C30040);
    rdc(12'h108, 32'h3);
    // Byte write into lane 1 of the transmit K word
    @(posedge ref_clk_i) hsize_i <= 3'h0;
    wr(12'h00D, 32'h0000EE00);
    hsize_i <= 3'h2;
    rdc(12'h00C, 32'hA5C3EE42);
    host.wr_rd(BASE | 32'h018, 32'h5A5A5A5A, rd, rsp);
    cmp({rsp, rd}, {1'b0, 32'h5A5A5A5A});
    $display("error test done");
  endtask
  task automatic t_hyper;
    int n;
    wr(12'h000, 32'h0);
    wr(12'h104, 32'h3);
    wr(12'h000, 32'hF);
    n = 0;
    while (hf_start_o !== 1'b1 && n < 50) begin
      tick;
      n++;
    end
    n = 0;
    do begin
      tick;
      n++;
    end while (hf_start_o !== 1'b1 && n < 50);
    cmp(n, 4);
    // Clock enable low freezes the counter; one count was taken before
    @(posedge ref_clk_i) ce_i <= 1'b0;
    repeat (8) @(posedge ref_clk_i);
    ce_i <= 1'b1;
    n = 0;
    do begin
      tick;
      n++;
    end while (hf_start_o !== 1'b1 && n < 50);
    cmp(n, 3);
    $display("hyperframe test done");
  endtask
  task automatic t_timeout;
    int n;
    wr(12'h000, 32'h0);
    wr(12'h100, 32'h5);
    wr(12'h000, 32'hF);
    n = 0;
    while (sync_timeout_o !== 1'b1 && n < 30) begin
      tick;
      n++;
    end
    cmp(n >= 5 && n <= 10, 1'b1);
    @(posedge ref_clk_i) sync_ok_i <= 1'b1;
    repeat (3) tick;
    cmp(sync_timeout_o, 1'b0);
    $display("timeout test done");
  endtask
  task automatic t_rel;
    @(posedge ref_clk_i) pll_lock_i <= 1'b0;
    repeat (2) tick;
    cmp({bus_rst_n_o, lane_tx_rst_n_o, lane_rx_rst_n_o}, 3'h3);
    @(posedge ref_clk_i) init_done_i <= 1'b0;
    repeat (3) tick;
    cmp({lane_tx_rst_n_o, lane_rx_rst_n_o, core_en_o}, 3'h0);
    @(posedge ref_clk_i) external_reset_n_i <= 1'b0;
    pll_lock_i <= 1'b1;
    init_done_i <= 1'b1;
    repeat (2) tick;
    cmp({bus_rst_n_o, lane_tx_rst_n_o}, 2'h0);
    @(posedge ref_clk_i) external_reset_n_i <= 1'b1;
    repeat (3) tick;
    cmp({bus_rst_n_o, lane_tx_rst_n_o, lane_rx_rst_n_o}, 3'h7);
    rdc(12'h000, 32'h0);
    $display("reset release test done");
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // 200 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  // Main sequence
  initial begin
    sys_rst_i = 1'b1;
    ce_i = 1'b1;
    external_reset_n_i = 1'b1;
    pll_lock_i = 1'b1;
    init_done_i = 1'b1;
    sync_ok_i = 1'b0;
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) tick;
    t_reset;
    t_program;
    t_error;
    t_hyper;
    t_timeout;
    t_rel;
    results;
  end
  // Whole run needs about a microsecond; a hang ends it here
  initial begin
    #20us;
    err_total++;
    results;
  end
endmodule
`default_nettype wire
